// File: dio_strap_interrupt_buffer_logic.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dio_strap_interrupt_buffer_logic
  import dio_strap_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = VENDOR_ID_DEF,
  parameter logic [15:0] DEVICE_ID_PLAIN = DEVICE_ID_PLAIN_DEF,
  parameter logic [15:0] DEVICE_ID_COS = DEVICE_ID_COS_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] port_c_bit3_irq_in,
  input wire logic ext_irq_strap_grp0,
  input wire logic ext_irq_strap_grp1,
  input wire logic buffer_mode_strap,
  input wire logic cos_variant_strap,
  input wire logic cos_event,
  input wire logic [15:0] io_base,
  input wire logic [7:0] irq_line_cfg,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic hit,
  output logic [1:0] buf_enable,
  output logic [5:0] cos_irq_enable,
  output logic [7:0] irq_line,
  output logic [15:0] vendor_id,
  output logic [15:0] device_id,
  output logic irq
);
  // ==========================================================
  // Address decode
  logic [15:0] offs_full;
  logic [3:0] offs;
  logic sel;
  always_comb begin
    offs_full = addr - io_base;
    offs = offs_full[3:0];
    sel = (offs_full < 16'(WINDOW_BYTES));
  end
  assign hit = sel;

  // ==========================================================
  // Straps and edge detection
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_d;
  logic [1:0] strap_ff1;
  logic [1:0] strap_ff2;
  logic mode_ff1;
  logic mode_ff2;
  logic var_ff1;
  logic var_ff2;
  logic cos_ff1;
  logic cos_ff2;
  logic [1:0] ext_pulse;
  logic [1:0] ext_gated;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      sync_d <= 2'h0;
    end else begin
      sync_a <= port_c_bit3_irq_in;
      sync_b <= sync_a;
      sync_d <= sync_b;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ff1 <= 2'h0;
      strap_ff2 <= 2'h0;
      mode_ff1 <= 1'b0;
      mode_ff2 <= 1'b0;
      var_ff1 <= 1'b0;
      var_ff2 <= 1'b0;
      cos_ff1 <= 1'b0;
      cos_ff2 <= 1'b0;
    end else begin
      strap_ff1 <= {ext_irq_strap_grp1, ext_irq_strap_grp0};
      strap_ff2 <= strap_ff1;
      mode_ff1 <= buffer_mode_strap;
      mode_ff2 <= mode_ff1;
      var_ff1 <= cos_variant_strap;
      var_ff2 <= var_ff1;
      cos_ff1 <= cos_event;
      cos_ff2 <= cos_ff1;
    end
  end

  // One-cycle pulse per rising edge, then strap gate
  assign ext_pulse = sync_b & ~sync_d;
  assign ext_gated = ext_pulse & strap_ff2;

  // ==========================================================
  // Buffer control
  logic [1:0] buf_dis;
  logic ctrl_wr0;
  logic ctrl_wr1;
  assign ctrl_wr0 = wr && sel && (offs == OFS_CTRL_GRP0);
  assign ctrl_wr1 = wr && sel && (offs == OFS_CTRL_GRP1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_dis <= BUF_DIS_RST;
    end else begin
      if (ctrl_wr0) begin
        buf_dis[0] <= wdata[MODE_SET_FLAG_POS];
      end
      if (ctrl_wr1) begin
        buf_dis[1] <= wdata[MODE_SET_FLAG_POS];
      end
    end
  end

  // Strap high selects always-on setting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_enable <= 2'h0;
    end else if (mode_ff2) begin
      buf_enable <= 2'h3;
    end else begin
      buf_enable <= ~buf_dis;
    end
  end

  // ==========================================================
  // Change-of-state enable register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cos_irq_enable <= COS_EN_RST;
    end else if (wr && sel && offs == OFS_COS_ENABLE) begin
      cos_irq_enable <= wdata[5:0];
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] set_vec;
  logic [2:0] clr_vec;
  logic [2:0] pending;
  always_comb begin
    set_vec = {cos_ff2, ext_gated};
    clr_vec = 3'h0;
    if (wr && sel && offs == OFS_IRQ_STATUS) begin
      clr_vec = wdata[2:0];
    end
    if (wr && sel && offs == OFS_COS_CLEAR) begin
      clr_vec[ST_COS_POS] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= IRQ_STATUS_RST;
    end else begin
      irq_status <= (irq_status & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr && sel && offs == OFS_IRQ_MASK) begin
      irq_mask <= wdata[2:0];
    end
  end

  assign pending = irq_status & irq_mask;
  assign irq = (pending[ST_EXT0_POS] | pending[ST_EXT1_POS]) | pending[ST_COS_POS];

  // ==========================================================
  // Read data and identity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd && sel) begin
      case (offs)
        OFS_IRQ_STATUS: rdata <= {5'h00, irq_status};
        OFS_IRQ_MASK: rdata <= {5'h00, irq_mask};
        OFS_STRAP_STAT: rdata <= {2'h0, buf_enable, var_ff2, mode_ff2, strap_ff2};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vendor_id <= 16'h0000;
      device_id <= 16'h0000;
      irq_line <= 8'h00;
    end else begin
      vendor_id <= VENDOR_ID;
      device_id <= var_ff2 ? DEVICE_ID_COS : DEVICE_ID_PLAIN;
      irq_line <= irq_line_cfg;
    end
  end

  // ==========================================================
  // Assertions
  a_edge_pulse_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[0] |=> !ext_pulse[0]) else $error("edge pulse longer than one cycle");
  a_edge_only_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[1] |-> $rose(sync_b[1])) else $error("pulse without rising edge");
  a_strap_gate_grp0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[0] && strap_ff2[0] |=> irq_status[ST_EXT0_POS])
    else $error("enabled edge not latched");
  a_strap_block_grp1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strap_ff2[1] && !irq_status[ST_EXT1_POS] |=> !irq_status[ST_EXT1_POS])
    else $error("disabled group latched interrupt");
  a_buf_always_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_ff2 |=> buf_enable == 2'h3) else $error("always-on buffers not enabled");
  a_buf_soft_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !mode_ff2 && !$past(mode_ff2) |-> buf_enable == ~$past(buf_dis))
    else $error("buffer enable not following latch");
  a_flag_disables: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_wr0 && wdata[MODE_SET_FLAG_POS] |=> buf_dis[0]) else $error("flag high kept enable");
  a_irq_or_combine: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == (|(irq_status & irq_mask))) else $error("interrupt OR mismatch");
  a_window_hit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hit |-> (addr - io_base) <= 16'h000f) else $error("hit outside window");
  a_device_id_var: assert property (@(posedge ref_clk) disable iff (!rst_n)
    var_ff2 |=> device_id == DEVICE_ID_COS) else $error("wrong device id");

  // ==========================================================
  // Assertions, remaining edge, strap and flag checks for both groups
  a_edge_pulse_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[1] |=> !ext_pulse[1])
    else $error("group 1 edge pulse longer than one cycle");
  a_edge_rise_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[0] |-> $rose(sync_b[0]))
    else $error("group 0 pulse without rising edge");
  a_strap_gate_grp1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_pulse[1] && strap_ff2[1] |=> irq_status[ST_EXT1_POS])
    else $error("enabled group 1 edge not latched");
  a_strap_block_grp0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strap_ff2[0] && !irq_status[ST_EXT0_POS] |=> !irq_status[ST_EXT0_POS])
    else $error("disabled group 0 latched interrupt");
  a_flag_disables_grp1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_wr1 && wdata[MODE_SET_FLAG_POS] |=> buf_dis[1])
    else $error("group 1 flag high kept enable");
  a_flag_enables_grp0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_wr0 && !wdata[MODE_SET_FLAG_POS] |=> !buf_dis[0])
    else $error("group 0 flag low kept disable");
  a_flag_enables_grp1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_wr1 && !wdata[MODE_SET_FLAG_POS] |=> !buf_dis[1])
    else $error("group 1 flag low kept disable");

  // ==========================================================
  // Assertions, status, read data, enables and identity
  a_cos_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cos_ff2 |=> irq_status[ST_COS_POS])
    else $error("change-of-state event not latched");
  a_status_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|set_vec) && !(|clr_vec) |=> irq_status == $past(irq_status))
    else $error("status changed without event");
  a_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clr_vec[ST_EXT0_POS] && !set_vec[ST_EXT0_POS] |=> !irq_status[ST_EXT0_POS])
    else $error("status bit not cleared");
  a_status_to_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_status[ST_COS_POS] && irq_mask[ST_COS_POS] |-> irq)
    else $error("unmasked status without interrupt");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rd && sel) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_cos_en_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && sel && offs == OFS_COS_ENABLE |=> cos_irq_enable == $past(wdata[5:0]))
    else $error("change-of-state enable not written");
  a_vendor_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> vendor_id == VENDOR_ID)
    else $error("wrong vendor code");
  a_device_id_plain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !var_ff2 |=> device_id == DEVICE_ID_PLAIN)
    else $error("wrong plain device id");
  a_irq_line_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> irq_line == $past(irq_line_cfg))
    else $error("interrupt line not taken");
  a_buf_on_soft: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !mode_ff2 && !$past(mode_ff2) && !$past(buf_dis[1]) |-> buf_enable[1])
    else $error("group 1 buffers not enabled");
endmodule
`default_nettype wire

// File: dio_strap_pkg.sv
package dio_strap_pkg;
  // Register map (byte offsets inside the 16-location window)
  localparam logic [3:0] OFS_CTRL_GRP0 = 4'h3;
  localparam logic [3:0] OFS_CTRL_GRP1 = 4'h7;
  localparam logic [3:0] OFS_COS_ENABLE = 4'hb;
  localparam logic [3:0] OFS_COS_CLEAR = 4'hf;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'hc;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hd;
  localparam logic [3:0] OFS_STRAP_STAT = 4'he;
  // Field positions
  localparam int MODE_SET_FLAG_POS = 7;
  localparam int ST_EXT0_POS = 0;
  localparam int ST_EXT1_POS = 1;
  localparam int ST_COS_POS = 2;
  // Window size and address width
  localparam int WINDOW_BYTES = 16;
  localparam int IO_ADDR_W = 16;
  // Reset values
  localparam logic [1:0] BUF_DIS_RST = 2'h0;
  localparam logic [2:0] IRQ_STATUS_RST = 3'h0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [5:0] COS_EN_RST = 6'h0;
  localparam logic [15:0] IO_BASE_RST = 16'h0000;
  // Identity codes: arbitrary neutral values
  localparam logic [15:0] VENDOR_ID_DEF = 16'h1234;
  localparam logic [15:0] DEVICE_ID_PLAIN_DEF = 16'h0001;
  localparam logic [15:0] DEVICE_ID_COS_DEF = 16'h0002;
endpackage

// File: host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host side: system-assigned base and interrupt line
module host_model #(
  parameter logic [15:0] BASE = 16'hfff0,
  parameter logic [7:0] LINE = 8'h0b
) (
  output logic [15:0] io_base,
  output logic [7:0] irq_line_cfg
);
  assign io_base = BASE;
  assign irq_line_cfg = LINE;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dio_strap_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] pc_in = 2'h0;
  logic strap0 = 1'b1;
  logic strap1 = 1'b0;
  logic buf_mode = 1'b0;
  logic variant = 1'b0;
  logic cos_ev = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] io_base, vendor_id, device_id;
  logic [7:0] irq_line_cfg, rdata, irq_line;
  logic [5:0] cos_irq_enable;
  logic [1:0] buf_enable;
  logic hit, irq;
  int failures = 0;
  int compares = 0;
  logic [15:0] probe [4] = '{16'hffef, 16'hfff0, 16'h0000, 16'hffff};

  host_model hm (.io_base(io_base), .irq_line_cfg(irq_line_cfg));
  dio_strap_interrupt_buffer_logic dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .port_c_bit3_irq_in(pc_in),
    .ext_irq_strap_grp0(strap0), .ext_irq_strap_grp1(strap1),
    .buffer_mode_strap(buf_mode), .cos_variant_strap(variant), .cos_event(cos_ev),
    .io_base(io_base), .irq_line_cfg(irq_line_cfg), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .hit(hit), .buf_enable(buf_enable),
    .cos_irq_enable(cos_irq_enable), .irq_line(irq_line), .vendor_id(vendor_id),
    .device_id(device_id), .irq(irq)
  );

  always #25 ref_clk = ~ref_clk;

  // ==========
  // Bus and check tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] ofs, input logic [7:0] data);
    @(posedge ref_clk);
    addr <= io_base + {12'h000, ofs};
    wdata <= data;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] ofs, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= io_base + {12'h000, ofs};
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 check(16'(rdata), 16'(exp));
  endtask
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    #1 check(16'(irq), 16'(exp));
    if (n == 10) wrap_up();
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    check(vendor_id, VENDOR_ID_DEF);
    check(device_id, DEVICE_ID_PLAIN_DEF);
    check(16'(irq_line), 16'h000b);
    check(16'(buf_enable), 16'h0003);
    variant <= 1'b1;
    settle();
    check(device_id, DEVICE_ID_COS_DEF);
    variant <= 1'b0;
    $display("test identity done");
    wr_reg(OFS_CTRL_GRP0, 8'h89);
    settle();
    check(16'(buf_enable), 16'h0002);
    wr_reg(OFS_CTRL_GRP1, 8'h80);
    settle();
    check(16'(buf_enable), 16'h0000);
    rd_chk(OFS_STRAP_STAT, 8'h01);
    buf_mode <= 1'b1;
    settle();
    check(16'(buf_enable), 16'h0003);
    wr_reg(OFS_CTRL_GRP0, 8'h80);
    settle();
    check(16'(buf_enable), 16'h0003);
    buf_mode <= 1'b0;
    settle();
    check(16'(buf_enable), 16'h0000);
    wr_reg(OFS_CTRL_GRP0, 8'h09);
    wr_reg(OFS_CTRL_GRP1, 8'h00);
    settle();
    check(16'(buf_enable), 16'h0003);
    $display("test buffers done");
    wr_reg(OFS_IRQ_MASK, 8'h07);
    pc_in <= 2'h1;
    wait_irq(1'b1);
    rd_chk(OFS_IRQ_STATUS, 8'h01);
    wr_reg(OFS_IRQ_STATUS, 8'h01);
    settle();
    wait_irq(1'b0);
    pc_in <= 2'h3;
    settle();
    rd_chk(OFS_IRQ_STATUS, 8'h00);
    strap1 <= 1'b1;
    pc_in <= 2'h1;
    settle();
    pc_in <= 2'h3;
    wait_irq(1'b1);
    rd_chk(OFS_IRQ_STATUS, 8'h02);
    wr_reg(OFS_IRQ_STATUS, 8'h02);
    wr_reg(OFS_IRQ_MASK, 8'h00);
    cos_ev <= 1'b1;
    @(posedge ref_clk);
    cos_ev <= 1'b0;
    settle();
    rd_chk(OFS_IRQ_STATUS, 8'h04);
    wait_irq(1'b0);
    wr_reg(OFS_IRQ_MASK, 8'h04);
    wait_irq(1'b1);
    wr_reg(OFS_COS_CLEAR, 8'h00);
    wait_irq(1'b0);
    $display("test interrupts done");
    wr_reg(OFS_COS_ENABLE, 8'h3f);
    settle();
    check(16'(cos_irq_enable), 16'h003f);
    rd_chk(4'h9, 8'h00);
    foreach (probe[i]) begin
      @(posedge ref_clk);
      addr <= probe[i];
      @(negedge ref_clk);
      check(16'(hit), 16'(i[0]));
    end
    $display("test window done");
    wrap_up();
  end
endmodule
`default_nettype wire
